// ### hib_consts.svh
// constants for the hibernate power controller
// Function
// R1 - writing 00 to the switch rate field turns the regulator off, hibernate
// R2 - hibernate stops core and system clocks and drops internal supply to zero
// R3 - in hibernate every external pin is three-stated unless stated otherwise
// R4 - ethernet or CAN unit wake request restarts the regulator
// R5 - low level on the PHY wake pin wakes; any device may pull it
// R6 - RTC wake event or reset pin also restarts the regulator
// R7 - every wake runs the full hardware reset sequence, never resumes
// R8 - each wake source has its own enable; disabled sources never wake
// R9 - only regulator control (and RTC) survive hibernate; rest resets
// R10 - sdram clock enable held low through wake when hold-low set
// R11 - software saves critical state externally before commanding hibernate
// R12 - supply level selected in 50 mV steps, regulator follows it
// R13 - core power can be removed while I/O supply stays on
// R14 - software may change supply level and core clock at run time
// R15 - wake re-enables regulator, holds reset until supply stable, then releases
`ifndef HIB_CONSTS_SVH
`define HIB_CONSTS_SVH
`define HIB_ADDR_VRCTL 12'h000
`define HIB_ADDR_STATUS 12'h004
`define HIB_ADDR_CLKCTL 12'h008
`define HIB_RATE_LSB 0
`define HIB_RATE_OFF 2'h0
`define HIB_RATE_RST 2'h3
`define HIB_LEVEL_LSB 4
`define HIB_LEVEL_RST 4'h8
`define HIB_WAKE_EN_LSB 8
`define HIB_WAKE_EN_RST 5'h10
`define HIB_HOLD_BIT 13
`define HIB_CORE_OFF_BIT 14
`define HIB_CORE_DIV_RST 4'h1
`define HIB_SYS_DIV_RST 4'h4
`define HIB_CORE_DIV_LSB 0
`define HIB_SYS_DIV_LSB 4
`define HIB_ST_STATE_LSB 0
`define HIB_ST_CAUSE_LSB 8
`define HIB_ST_STABLE_BIT 16
`define HIB_ST_LEVEL_LSB 20
`define HIB_NSRC 5
`define HIB_SRC_ETH 0
`define HIB_SRC_CAN 1
`define HIB_SRC_PHY 2
`define HIB_SRC_RTC 3
`define HIB_SRC_RSTPIN 4
`define HIB_CLK_NS 100
`define HIB_RESET_HOLD_CYC 11
`define HIB_STEP_NS 1000
`define HIB_STEP_CYC ((`HIB_STEP_NS + `HIB_CLK_NS - 1) / `HIB_CLK_NS)
`define HIB_LEVEL_STEP_MV 50
`endif

// ### hib_pkg.sv
// types for the hibernate power controller
package hib_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HIBERNATE,
    ST_POWER_UP,
    ST_RESET_SEQ
  } hib_state_e;
  typedef logic [3:0] level_t;
endpackage

// ### wake_detect.sv
// per-source wake qualification and cause capture
`timescale 1ns/1ps
`include "hib_consts.svh"
module wake_detect (
  input wire logic i_core_clk, // core clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_armed, // high while hibernating
  input wire logic [`HIB_NSRC-1:0] i_src, // wake requests, active high
  input wire logic [`HIB_NSRC-1:0] i_en, // per-source enables
  output logic o_wake, // one-cycle wake pulse
  output logic [`HIB_NSRC-1:0] o_cause // sources that caused the wake
);
  logic [`HIB_NSRC-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < `HIB_NSRC; g = g + 1) begin : g_src
      assign hit[g] = i_src[g] & i_en[g]; // R8
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_armed & (|hit) & ~o_wake;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cause <= '0;
    end else if (i_armed & (|hit) & ~o_wake) begin
      o_cause <= hit;
    end
  end
endmodule

// ### level_stepper.sv
// regulator level ramp, one 50 mV code per step interval
`timescale 1ns/1ps
`include "hib_consts.svh"
module level_stepper
  import hib_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_enable, // regulator on
  input wire level_t i_target, // programmed level code
  output level_t o_level // driven level code, 0 = off
);
  localparam int STEP = `HIB_STEP_CYC;
  logic [7:0] tick;
  logic step;

  // slow ramp avoids big supply jumps while the core runs
  assign step = (tick == 8'(STEP - 1));

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick <= 8'h00;
    end else if (!i_enable || step || o_level == i_target) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= 4'h0;
    end else if (!i_enable) begin
      o_level <= 4'h0; // R2
    end else if (step && o_level < i_target) begin
      o_level <= o_level + 4'h1; // R12
    end else if (step && o_level > i_target) begin
      o_level <= o_level - 4'h1; // R12
    end
  end
endmodule

// ### hib_power_ctrl.sv
// hibernate and dynamic voltage controller with apb registers
`timescale 1ns/1ps
`include "hib_consts.svh"
module hib_power_ctrl
  import hib_pkg::*;
(
  input wire logic i_core_clk, // 10 MHz clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  input wire logic i_eth_wake, // ethernet wake request
  input wire logic i_can_wake, // can wake request
  input wire logic i_phy_wake_input_n, // phy wake pin, active low
  input wire logic i_rtc_wake, // rtc wake event
  input wire logic i_reset_pin_n, // external reset pin, active low
  input wire logic i_supply_stable, // internal supply good
  input wire logic i_sdram_clken_req, // sdram clock enable from controller
  output logic o_regulator_en, // regulator on
  output level_t o_vdd_level, // internal supply level code
  output logic o_core_pwr_en, // core power switch
  output logic o_core_clk_en, // core clock gate
  output logic o_sys_clk_en, // system clock gate
  output logic [3:0] o_core_clk_div, // core clock ratio
  output logic [3:0] o_sys_clk_div, // system clock ratio
  output logic o_pins_oe_n, // pin drivers except sdram clock enable, low = driving
  output logic o_logic_nrst, // internal logic reset, active low
  output logic o_sdram_clken, // sdram clock enable pin value
  output logic o_sdram_clken_oe_n, // sdram clock enable pin enable
  output logic o_hibernate // high while hibernating
);
  hib_state_e state;
  hib_state_e next_state;
  logic [1:0] rate;
  level_t level;
  logic [`HIB_NSRC-1:0] wake_en;
  logic hold_low;
  logic core_off;
  logic [3:0] core_div;
  logic [3:0] sys_div;
  logic [3:0] hold_cnt;
  logic sdram_held;
  logic wake;
  logic [`HIB_NSRC-1:0] cause;
  logic [`HIB_NSRC-1:0] srcs;
  level_t ramp_level;
  logic access;
  logic wr;
  logic rd;
  logic hit_vr;
  logic hit_st;
  logic hit_clk;
  logic bad;
  logic enter_hib;
  logic running;
  logic [31:0] vr_word;
  logic [31:0] st_word;
  logic [31:0] clk_word;
  logic [31:0] next_rdata;

  assign running = (state == ST_RUN);
  // bus ignores writes and answers every access with an error outside the run state
  assign access = i_psel & i_penable;
  assign wr = access & o_pready & i_pwrite & running;
  assign rd = access & ~o_pready;

  always_comb begin
    hit_vr = 1'b0;
    hit_st = 1'b0;
    hit_clk = 1'b0;
    if (i_paddr == `HIB_ADDR_VRCTL) begin
      hit_vr = 1'b1;
    end else if (i_paddr == `HIB_ADDR_STATUS) begin
      hit_st = 1'b1;
    end else if (i_paddr == `HIB_ADDR_CLKCTL) begin
      hit_clk = 1'b1;
    end
  end

  assign bad = ~(hit_vr | hit_st | hit_clk) | (hit_st & i_pwrite) | ~running;
  assign enter_hib = wr & hit_vr &
    (i_pwdata[`HIB_RATE_LSB +: 2] == `HIB_RATE_OFF); // R1

  // words built field by field so the layout lives in one place
  always_comb begin
    vr_word = 32'h00000000;
    vr_word[`HIB_RATE_LSB +: 2] = rate;
    vr_word[`HIB_LEVEL_LSB +: 4] = level;
    vr_word[`HIB_WAKE_EN_LSB +: `HIB_NSRC] = wake_en;
    vr_word[`HIB_HOLD_BIT] = hold_low;
    vr_word[`HIB_CORE_OFF_BIT] = core_off;
  end

  always_comb begin
    st_word = 32'h00000000;
    st_word[`HIB_ST_STATE_LSB +: 2] = state;
    st_word[`HIB_ST_CAUSE_LSB +: `HIB_NSRC] = cause;
    st_word[`HIB_ST_STABLE_BIT] = i_supply_stable;
    st_word[`HIB_ST_LEVEL_LSB +: 4] = ramp_level;
  end

  always_comb begin
    clk_word = 32'h00000000;
    clk_word[`HIB_CORE_DIV_LSB +: 4] = core_div;
    clk_word[`HIB_SYS_DIV_LSB +: 4] = sys_div;
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_vr) begin
      next_rdata = vr_word;
    end else if (hit_st) begin
      next_rdata = st_word;
    end else if (hit_clk) begin
      next_rdata = clk_word;
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= rd;
      o_pslverr <= rd & bad;
      if (rd && !i_pwrite && !bad) begin
        o_prdata <= next_rdata;
      end else if (rd) begin
        o_prdata <= 32'h00000000;
      end
    end
  end

  // regulator control survives hibernate: only the async reset i_nrst clears it, but power-up resets a rate of 00
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rate <= `HIB_RATE_RST;
      level <= `HIB_LEVEL_RST;
      wake_en <= `HIB_WAKE_EN_RST;
      hold_low <= 1'b0;
      core_off <= 1'b0;
    end else if (wr && hit_vr && !bad) begin
      rate <= i_pwdata[`HIB_RATE_LSB +: 2];
      level <= i_pwdata[`HIB_LEVEL_LSB +: 4]; // R14
      wake_en <= i_pwdata[`HIB_WAKE_EN_LSB +: `HIB_NSRC]; // R8
      hold_low <= i_pwdata[`HIB_HOLD_BIT];
      core_off <= i_pwdata[`HIB_CORE_OFF_BIT]; // R13
    end else if (state == ST_POWER_UP && rate == `HIB_RATE_OFF) begin
      // so the rate reads back at its reset value; hibernate entry only follows a write of 00
      rate <= `HIB_RATE_RST;
    end
  end

  // clock ratios are volatile and come back at defaults
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      core_div <= `HIB_CORE_DIV_RST;
      sys_div <= `HIB_SYS_DIV_RST;
    end else if (state == ST_HIBERNATE) begin
      core_div <= `HIB_CORE_DIV_RST; // R9
      sys_div <= `HIB_SYS_DIV_RST; // R9
    end else if (wr && hit_clk && !bad) begin
      core_div <= i_pwdata[`HIB_CORE_DIV_LSB +: 4]; // R14
      sys_div <= i_pwdata[`HIB_SYS_DIV_LSB +: 4]; // R14
    end
  end

  always_comb begin
    srcs = '0;
    srcs[`HIB_SRC_ETH] = i_eth_wake; // R4
    srcs[`HIB_SRC_CAN] = i_can_wake; // R4
    srcs[`HIB_SRC_PHY] = ~i_phy_wake_input_n; // R5
    srcs[`HIB_SRC_RTC] = i_rtc_wake; // R6
    srcs[`HIB_SRC_RSTPIN] = ~i_reset_pin_n; // R6
  end

  wake_detect u_wake (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_armed(state == ST_HIBERNATE),
    .i_src(srcs),
    .i_en(wake_en),
    .o_wake(wake),
    .o_cause(cause)
  );

  level_stepper u_level (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_enable(state != ST_HIBERNATE),
    .i_target(level),
    .o_level(ramp_level)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (enter_hib) begin
          next_state = ST_HIBERNATE; // R1
        end
      end
      ST_HIBERNATE: begin
        if (wake) begin
          next_state = ST_POWER_UP; // R15
        end
      end
      ST_POWER_UP: begin
        if (i_supply_stable) begin
          next_state = ST_RESET_SEQ; // R15
        end
      end
      ST_RESET_SEQ: begin
        if (hold_cnt == 4'(`HIB_RESET_HOLD_CYC - 1)) begin
          next_state = ST_RUN; // R7
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_cnt <= 4'h0;
    end else if (state == ST_RESET_SEQ) begin
      hold_cnt <= hold_cnt + 4'h1;
    end else begin
      hold_cnt <= 4'h0;
    end
  end

  // sdram hold is armed at hibernate entry, released by software clearing the bit
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sdram_held <= 1'b0;
    end else if (enter_hib) begin
      sdram_held <= i_pwdata[`HIB_HOLD_BIT]; // R10
    end else if (!hold_low) begin
      sdram_held <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_regulator_en <= 1'b1;
    end else begin
      o_regulator_en <= (next_state != ST_HIBERNATE); // R1
    end
  end

  // level drops at once in hibernate instead of waiting for the ramp
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_vdd_level <= 4'h0;
    end else if (state == ST_HIBERNATE) begin
      o_vdd_level <= 4'h0; // R2
    end else begin
      o_vdd_level <= ramp_level; // R12
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_pwr_en <= 1'b1;
    end else begin
      o_core_pwr_en <= (next_state == ST_RUN) & ~core_off; // R13
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_clk_en <= 1'b1;
      o_sys_clk_en <= 1'b1;
    end else begin
      o_core_clk_en <= (next_state == ST_RUN); // R2
      o_sys_clk_en <= (next_state == ST_RUN); // R2
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_clk_div <= `HIB_CORE_DIV_RST;
      o_sys_clk_div <= `HIB_SYS_DIV_RST;
    end else begin
      o_core_clk_div <= core_div;
      o_sys_clk_div <= sys_div;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pins_oe_n <= 1'b0;
    end else begin
      o_pins_oe_n <= (next_state == ST_HIBERNATE); // R3
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_logic_nrst <= 1'b0;
    end else begin
      o_logic_nrst <= (next_state == ST_RUN); // R7 R15
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hibernate <= 1'b0;
    end else begin
      o_hibernate <= (next_state == ST_HIBERNATE);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sdram_clken <= 1'b0;
      o_sdram_clken_oe_n <= 1'b0;
    end else if (next_state == ST_HIBERNATE) begin
      o_sdram_clken <= 1'b0;
      o_sdram_clken_oe_n <= 1'b1; // R3
    end else if (sdram_held || (enter_hib && i_pwdata[`HIB_HOLD_BIT])) begin
      o_sdram_clken <= 1'b0; // R10
      o_sdram_clken_oe_n <= 1'b0;
    end else begin
      o_sdram_clken <= i_sdram_clken_req & (next_state == ST_RUN);
      o_sdram_clken_oe_n <= 1'b0;
    end
  end
endmodule

// ### hib_power_ctrl_properties.sv
// checker for the hibernate power controller ports
`timescale 1ns/1ps
`include "hib_consts.svh"
module hib_power_ctrl_checker
  import hib_pkg::*;
(
  input wire logic i_core_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_psel, // apb
  input wire logic i_penable, // apb
  input wire logic i_pwrite, // apb
  input wire logic [11:0] i_paddr, // apb
  input wire logic [31:0] i_pwdata, // apb
  input wire logic o_pready, // apb
  input wire logic o_pslverr, // apb
  input wire logic i_eth_wake, // wake
  input wire logic i_can_wake, // wake
  input wire logic i_phy_wake_input_n, // wake
  input wire logic i_rtc_wake, // wake
  input wire logic i_reset_pin_n, // wake
  input wire logic i_supply_stable, // supply good
  input wire logic o_regulator_en, // regulator
  input wire level_t o_vdd_level, // level
  input wire logic o_core_clk_en, // gate
  input wire logic o_sys_clk_en, // gate
  input wire logic o_pins_oe_n, // pins
  input wire logic o_logic_nrst, // internal reset
  input wire logic o_sdram_clken, // cke
  input wire logic o_hibernate // state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic [14:0] cfg;
  logic from_hib;
  logic hold;
  logic vr_wr;
  logic [4:0] act;
  assign vr_wr = i_psel && i_penable && o_pready && !o_pslverr && i_pwrite
    && i_paddr == `HIB_ADDR_VRCTL;
  assign act = cfg[12:8]
    & {!i_reset_pin_n, i_rtc_wake, !i_phy_wake_input_n, i_can_wake, i_eth_wake};
  // shadow of the retained control word
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg <= 15'h1083;
    end else if (vr_wr) begin
      cfg <= i_pwdata[14:0];
    end
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      from_hib <= 1'h0;
      hold <= 1'h0;
    end else begin
      from_hib <= o_hibernate || (from_hib && !o_logic_nrst);
      hold <= cfg[13] && (o_hibernate || hold);
    end
  end
  chk_entry_off: assert property (vr_wr && i_pwdata[1:0] == `HIB_RATE_OFF |=> o_hibernate)
    else $error("no hibernate after regulator off write");
  chk_hib_clocks: assert property (o_hibernate |-> !o_core_clk_en && !o_sys_clk_en && !o_regulator_en)
    else $error("clocks or regulator on in hibernate");
  chk_hib_level: assert property (o_hibernate && $past(o_hibernate) |-> o_vdd_level == 4'h0)
    else $error("supply level not zero in hibernate");
  chk_hib_pins: assert property (o_hibernate |-> o_pins_oe_n)
    else $error("pins driven in hibernate");
  chk_wake_enabled: assert property (o_hibernate && |act |-> ##[1:3] !o_hibernate)
    else $error("enabled wake ignored");
  chk_wake_disabled: assert property (o_hibernate && act == 5'h0 && $past(act) == 5'h0
    && $past(act, 2) == 5'h0 |=> o_hibernate)
    else $error("left hibernate without enabled wake");
  chk_wake_power: assert property ($fell(o_hibernate) |-> o_regulator_en && !o_pins_oe_n && !o_logic_nrst)
    else $error("wake did not restart regulator in reset");
  chk_reset_hold: assert property (from_hib && o_logic_nrst |-> $past(i_supply_stable, 11))
    else $error("reset released too early after wake");
  chk_cke_hold: assert property (hold && cfg[13] && !o_hibernate |-> !o_sdram_clken)
    else $error("sdram clock enable not held low");
endmodule
bind hib_power_ctrl hib_power_ctrl_checker chk (.*);

// ### hib_supply_model.sv
// supply-good and phy wake pin model for the hibernate controller bench
`timescale 1ns/1ps
module hib_supply_model #(
  parameter int SETTLE = 6
) (
  input wire logic i_core_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_regulator_en, // regulator on
  input wire logic i_phy_pull, // some device pulls the pin down
  output logic o_supply_stable, // supply good
  output logic o_phy_pin // phy wake pin level
);
  int cnt;
  // pull-up keeps the pin high when nobody pulls it
  assign o_phy_pin = i_phy_pull ? 1'h0 : 1'h1;
  // supply only good some time after the regulator turns on
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 0;
      o_supply_stable <= 1'h0;
    end else if (!i_regulator_en) begin
      cnt <= 0;
      o_supply_stable <= 1'h0;
    end else if (cnt < SETTLE) begin
      cnt <= cnt + 1;
    end else begin
      o_supply_stable <= 1'h1;
    end
  end
endmodule

// ### tb_hib_power_ctrl.sv
// self-checking bench for the hibernate power controller
`timescale 1ns/1ps
module tb_hib_power_ctrl;
  import hib_pkg::*;
  typedef struct {logic [31:0] wd; logic [4:0] src; logic exp;} row_s;
  logic i_core_clk, i_nrst, i_psel, i_penable, i_pwrite, i_eth_wake, i_can_wake, i_rtc_wake;
  logic i_phy_wake_input_n, i_reset_pin_n, i_supply_stable, i_sdram_clken_req, phy_pull, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, saved;
  logic o_pready, o_pslverr, o_regulator_en, o_core_pwr_en, o_core_clk_en, o_sys_clk_en;
  logic o_pins_oe_n, o_logic_nrst, o_sdram_clken, o_sdram_clken_oe_n, o_hibernate;
  logic [3:0] o_core_clk_div, o_sys_clk_div;
  level_t o_vdd_level;
  int failures, compares;
  // control word, wake sources, expect wake
  row_s rows [9] = '{'{32'h0180, 5'h01, 1'h1}, '{32'h0380, 5'h02, 1'h1},
    '{32'h0580, 5'h04, 1'h1}, '{32'h0980, 5'h08, 1'h1}, '{32'h1180, 5'h10, 1'h1},
    '{32'h0180, 5'h02, 1'h0}, '{32'h0180, 5'h04, 1'h0}, '{32'h0180, 5'h08, 1'h0},
    '{32'h0180, 5'h10, 1'h0}};
  hib_power_ctrl dut (.*);
  hib_supply_model partner (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_regulator_en(o_regulator_en), .i_phy_pull(phy_pull),
    .o_supply_stable(i_supply_stable), .o_phy_pin(i_phy_wake_input_n));
  initial begin
    i_core_clk = 1'h0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", name, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (n >= 20) failures++;
  endtask
  task automatic fire(input logic [4:0] s);
    @(posedge i_core_clk);
    i_eth_wake <= s[0];
    i_can_wake <= s[1];
    phy_pull <= s[2];
    i_rtc_wake <= s[3];
    i_reset_pin_n <= ~s[4];
  endtask
  task automatic run_wait;
    int n;
    n = 0;
    while (o_logic_nrst !== 1'h1 && n < 200) begin
      @(posedge i_core_clk);
      n++;
    end
  endtask
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #3000000;
    failures++;
    summarize;
  end
  initial begin
    failures = 0;
    compares = 0;
    {i_psel, i_penable, i_pwrite, i_eth_wake, i_can_wake, i_rtc_wake, phy_pull} = 7'h00;
    i_reset_pin_n = 1'h1;
    i_sdram_clken_req = 1'h1;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_nrst = 1'h0;
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk("control reset", 32'h1083, rd);
    apb(1'h0, 12'h008, 32'h0);
    chk("clock reset", 32'h41, rd);
    apb(1'h0, 12'h00C, 32'h0);
    chk("unmapped error", 1, er);
    apb(1'h1, 12'h004, 32'hF);
    chk("status write error", 1, er);
    repeat (100) @(posedge i_core_clk);
    chk("level ramp", 8, o_vdd_level);
    apb(1'h1, 12'h000, 32'h5043);
    apb(1'h1, 12'h008, 32'h12);
    repeat (60) @(posedge i_core_clk);
    chk("level lowered", 4, o_vdd_level);
    chk("core divider", 2, o_core_clk_div);
    chk("sys divider", 1, o_sys_clk_div);
    chk("core power off", 0, o_core_pwr_en);
    foreach (rows[k]) begin
      apb(1'h1, 12'h008, 32'h23);
      apb(1'h0, 12'h008, 32'h0);
      saved = rd;
      apb(1'h1, 12'h000, rows[k].wd);
      repeat (3) @(posedge i_core_clk);
      chk("hibernate", 1, o_hibernate);
      chk("regulator off", 0, o_regulator_en);
      chk("supply off", 0, o_vdd_level);
      chk("clocks stopped", 0, {o_core_clk_en, o_sys_clk_en});
      chk("pins released", 1, o_pins_oe_n);
      chk("cke released", 1, o_sdram_clken_oe_n);
      fire(rows[k].src);
      repeat (6) @(posedge i_core_clk);
      chk("woken", rows[k].exp, !o_hibernate);
      if (!rows[k].exp) fire(5'h01);
      repeat (4) @(posedge i_core_clk);
      fire(5'h00);
      run_wait;
      chk("running", 1, o_logic_nrst);
      apb(1'h0, 12'h004, 32'h0);
      chk("wake cause", rows[k].exp ? rows[k].src : 5'h01, rd[12:8]);
      chk("state run", 0, rd[1:0]);
      apb(1'h0, 12'h000, 32'h0);
      chk("control kept", rows[k].wd | 32'h3, rd);
      apb(1'h0, 12'h008, 32'h0);
      chk("clock lost", 32'h41, rd);
      apb(1'h1, 12'h008, saved);
      apb(1'h0, 12'h008, 32'h0);
      chk("clock restored", 32'h23, rd);
    end
    apb(1'h1, 12'h000, 32'h2180);
    fire(5'h01);
    repeat (6) @(posedge i_core_clk);
    fire(5'h00);
    run_wait;
    chk("cke held", 0, o_sdram_clken);
    apb(1'h1, 12'h000, 32'h0183);
    repeat (3) @(posedge i_core_clk);
    chk("cke free", 1, o_sdram_clken);
    summarize;
  end
endmodule
